/* File: pkg/cu_buffer_pkg.sv */
`default_nettype none
package cu_buffer_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CS_PTR_OFFSET = 8'h08;
  localparam logic [7:0] CS_DATA_OFFSET = 8'h0C;
  localparam logic [7:0] USR_PTR_OFFSET = 8'h10;
  localparam logic [7:0] USR_DATA_OFFSET = 8'h14;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int CTRL_TWO_BYTE = 0;
  localparam int CTRL_READ_CHAN_B = 1;
  localparam int CTRL_INHIBIT = 2;
  localparam int CTRL_USER_BLOCK = 3;
  localparam int CTRL_XFER_IRQ_EN = 4;
  localparam int CTRL_WIDTH = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // ----------------------------------------
  // block geometry and check byte
  // ----------------------------------------
  localparam int NUM_WORDS = 24;
  localparam logic [4:0] LAST_WORD = 5'h17;
  localparam logic [7:0] LAST_FRAME = 8'hBF;
  localparam logic [7:0] CRC_FIRST_FRAME = 8'hB8;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h1D;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* File: hw/cu_buffer_manager.sv */
`timescale 1ns/100ps
`default_nettype none

module cu_buffer_manager #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frameTick,
  input wire logic pinMode,
  input wire logic serialStatusIn,
  output logic statusBitA,
  output logic statusBitB,
  output logic userBitA,
  output logic userBitB,
  output logic bitStrobe,
  output logic blockStart,
  output logic xferIrq
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  wire logic rst = !rstSync;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] stageCs [0:cu_buffer_pkg::NUM_WORDS-1];
  logic [15:0] txCs [0:cu_buffer_pkg::NUM_WORDS-1];
  logic [15:0] stageUsr [0:cu_buffer_pkg::NUM_WORDS-1];
  logic [15:0] txUsr [0:cu_buffer_pkg::NUM_WORDS-1];

  logic [4:0] ctrl;
  logic [4:0] csWord;
  logic csHalf;
  logic [4:0] usrWord;
  logic usrHalf;
  logic [7:0] frameIdx;
  logic [7:0] copyCount;
  logic [7:0] crcA;
  logic [7:0] crcB;
  logic proA;
  logic proB;

  wire logic twoByte = ctrl[cu_buffer_pkg::CTRL_TWO_BYTE];
  wire logic readChanB = ctrl[cu_buffer_pkg::CTRL_READ_CHAN_B];
  wire logic inhibit = ctrl[cu_buffer_pkg::CTRL_INHIBIT];
  wire logic userBlock = ctrl[cu_buffer_pkg::CTRL_USER_BLOCK];
  wire logic irqEnable = ctrl[cu_buffer_pkg::CTRL_XFER_IRQ_EN];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic wrFire = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  wire logic rdFire = s_axi_arvalid && s_axi_arready;
  wire logic [7:0] wrOff = 8'(s_axi_awaddr);
  wire logic [7:0] rdOff = 8'(s_axi_araddr);
  wire logic lowLane = s_axi_wstrb[0];
  wire logic [7:0] wByte = s_axi_wdata[7:0];

  wire logic wrCtrl = wrFire && wrOff == cu_buffer_pkg::CTRL_OFFSET;
  wire logic wrCsPtr = wrFire && wrOff == cu_buffer_pkg::CS_PTR_OFFSET;
  wire logic wrCsData = wrFire && wrOff == cu_buffer_pkg::CS_DATA_OFFSET;
  wire logic wrUsrPtr = wrFire && wrOff == cu_buffer_pkg::USR_PTR_OFFSET;
  wire logic wrUsrData = wrFire && wrOff == cu_buffer_pkg::USR_DATA_OFFSET;
  wire logic wrKnown = wrCtrl || wrCsPtr || wrCsData || wrUsrPtr || wrUsrData
                    || wrOff == cu_buffer_pkg::STATUS_OFFSET;
  wire logic rdCsData = rdFire && rdOff == cu_buffer_pkg::CS_DATA_OFFSET;
  wire logic rdUsrData = rdFire && rdOff == cu_buffer_pkg::USR_DATA_OFFSET;

  // status data port: access advances the pointer
  wire logic csAccess = (wrCsData && lowLane) || rdCsData;
  wire logic usrAccess = (wrUsrData && lowLane) || rdUsrData;
  wire logic csStep = csAccess && (!twoByte || csHalf);
  wire logic usrStep = usrAccess && usrHalf;
  wire logic [4:0] csWordInc = (csWord == cu_buffer_pkg::LAST_WORD)
                            ? 5'h00 : csWord + 5'h01;
  wire logic [4:0] usrWordInc = (usrWord == cu_buffer_pkg::LAST_WORD)
                             ? 5'h00 : usrWord + 5'h01;
  wire logic [4:0] wPtrVal = (wByte[4:0] > cu_buffer_pkg::LAST_WORD)
                          ? cu_buffer_pkg::LAST_WORD : wByte[4:0];

  wire logic [15:0] csCur = stageCs[csWord];
  wire logic [15:0] usrCur = stageUsr[usrWord];
  // one-byte read picks by channel bit; two-byte read walks A then B
  wire logic csPickB = twoByte ? csHalf : readChanB;
  wire logic [7:0] csRdByte = csPickB ? csCur[7:0] : csCur[15:8];
  wire logic [7:0] usrRdByte = usrHalf ? usrCur[7:0] : usrCur[15:8];

  logic [31:0] rdValue;
  logic rdKnown;

  always_comb begin
    rdValue = 32'h0000_0000;
    rdKnown = 1'b1;
    unique case (rdOff)
      cu_buffer_pkg::CTRL_OFFSET: rdValue = {27'h0000000, ctrl};
      cu_buffer_pkg::STATUS_OFFSET:
        rdValue = {14'h0000, proB, proA, copyCount, frameIdx};
      cu_buffer_pkg::CS_PTR_OFFSET: rdValue = {26'h0000000, csHalf, csWord};
      cu_buffer_pkg::CS_DATA_OFFSET: rdValue = {24'h000000, csRdByte};
      cu_buffer_pkg::USR_PTR_OFFSET:
        rdValue = {26'h0000000, usrHalf, usrWord};
      cu_buffer_pkg::USR_DATA_OFFSET: rdValue = {24'h000000, usrRdByte};
      default: rdKnown = 1'b0;
    endcase
  end

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  // address and data are taken together once both are offered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cu_buffer_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                       && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                      && !s_axi_bvalid;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? cu_buffer_pkg::RESP_OKAY
                               : cu_buffer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cu_buffer_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdValue;
        s_axi_rresp <= rdKnown ? cu_buffer_pkg::RESP_OKAY
                               : cu_buffer_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // control and pointers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= cu_buffer_pkg::CTRL_RESET;
    end else if (wrCtrl && lowLane) begin
      ctrl <= wByte[cu_buffer_pkg::CTRL_WIDTH-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      csWord <= 5'h00;
      csHalf <= 1'b0;
    end else if (wrCsPtr && lowLane) begin
      csWord <= wPtrVal;
      csHalf <= 1'b0;
    end else if (csAccess) begin
      csHalf <= twoByte && !csHalf;
      if (csStep) begin
        csWord <= csWordInc;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      usrWord <= 5'h00;
      usrHalf <= 1'b0;
    end else if (wrUsrPtr && lowLane) begin
      usrWord <= wPtrVal;
      usrHalf <= 1'b0;
    end else if (usrAccess) begin
      usrHalf <= !usrHalf;
      if (usrStep) begin
        usrWord <= usrWordInc;
      end
    end
  end

  // ----------------------------------------
  // block timing and copy
  // ----------------------------------------
  wire logic lastFrame = frameTick && frameIdx == cu_buffer_pkg::LAST_FRAME;
  wire logic doCopy = lastFrame && !inhibit;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frameIdx <= 8'h00;
      copyCount <= 8'h00;
      xferIrq <= 1'b0;
    end else begin
      if (frameTick) begin
        frameIdx <= lastFrame ? 8'h00 : frameIdx + 8'h01;
      end
      if (doCopy) begin
        copyCount <= copyCount + 8'h01;
      end
      xferIrq <= doCopy && irqEnable;
    end
  end

  // staging writes; one-byte mode fills both halves of a status word only, user words always take one half per write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < cu_buffer_pkg::NUM_WORDS; i++) begin
        stageCs[i] <= cu_buffer_pkg::WORD_RESET;
        stageUsr[i] <= cu_buffer_pkg::WORD_RESET;
      end
    end else begin
      if (wrCsData && lowLane) begin
        if (!twoByte) begin
          stageCs[csWord] <= {wByte, wByte};
        end else if (!csHalf) begin
          stageCs[csWord][15:8] <= wByte;
        end else begin
          stageCs[csWord][7:0] <= wByte;
        end
      end
      if (wrUsrData && lowLane) begin
        if (!usrHalf) begin
          stageUsr[usrWord][15:8] <= wByte;
        end else begin
          stageUsr[usrWord][7:0] <= wByte;
        end
      end
    end
  end

  // whole block moves in one edge, so no host write can split it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < cu_buffer_pkg::NUM_WORDS; i++) begin
        txCs[i] <= cu_buffer_pkg::WORD_RESET;
        txUsr[i] <= cu_buffer_pkg::WORD_RESET;
      end
    end else if (doCopy) begin
      for (int i = 0; i < cu_buffer_pkg::NUM_WORDS; i++) begin
        txCs[i] <= stageCs[i];
        txUsr[i] <= stageUsr[i];
      end
    end
  end

  // ----------------------------------------
  // serial bit selection
  // ----------------------------------------
  wire logic [4:0] txWord = frameIdx[7:3];
  wire logic [2:0] bitPos = frameIdx[2:0];
  wire logic [15:0] csTxWord = txCs[txWord];
  wire logic [15:0] usrTxWord = txUsr[txWord];
  // msb of each byte leaves first
  wire logic [2:0] csBitSel = 3'h7 - bitPos;
  wire logic [3:0] usrBitSel = 4'hF - {bitPos, 1'b0};
  // pin mode feeds both channels from the serial pin
  wire logic rawA = pinMode ? serialStatusIn : csTxWord[{1'b1, csBitSel}];
  wire logic rawB = pinMode ? serialStatusIn : csTxWord[{1'b0, csBitSel}];
  wire logic firstFrame = frameIdx == 8'h00;
  wire logic inCrc = frameIdx >= cu_buffer_pkg::CRC_FIRST_FRAME;
  wire logic proNowA = firstFrame ? rawA : proA;
  wire logic proNowB = firstFrame ? rawB : proB;
  wire logic [7:0] crcSeedA = firstFrame ? cu_buffer_pkg::CRC_INIT : crcA;
  wire logic [7:0] crcSeedB = firstFrame ? cu_buffer_pkg::CRC_INIT : crcB;
  wire logic fbA = crcSeedA[7] ^ rawA;
  wire logic fbB = crcSeedB[7] ^ rawB;
  wire logic [7:0] next_crcA = {crcSeedA[6:0], 1'b0}
                            ^ (fbA ? cu_buffer_pkg::CRC_POLY : 8'h00);
  wire logic [7:0] next_crcB = {crcSeedB[6:0], 1'b0}
                            ^ (fbB ? cu_buffer_pkg::CRC_POLY : 8'h00);
  // last byte replaced by the running check value in a channel whose pro flag is set, msb first
  wire logic outA = (inCrc && proA) ? crcA[csBitSel] : rawA;
  wire logic outB = (inCrc && proB) ? crcB[csBitSel] : rawB;
  wire logic usrA = userBlock && usrTxWord[usrBitSel];
  wire logic usrB = userBlock && usrTxWord[usrBitSel - 4'h1];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      crcA <= cu_buffer_pkg::CRC_INIT;
      crcB <= cu_buffer_pkg::CRC_INIT;
      proA <= 1'b0;
      proB <= 1'b0;
    end else if (frameTick) begin
      proA <= proNowA;
      proB <= proNowB;
      if (!inCrc) begin
        crcA <= next_crcA;
        crcB <= next_crcB;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      statusBitA <= 1'b0;
      statusBitB <= 1'b0;
      userBitA <= 1'b0;
      userBitB <= 1'b0;
      bitStrobe <= 1'b0;
      blockStart <= 1'b0;
    end else begin
      bitStrobe <= frameTick;
      blockStart <= frameTick && firstFrame;
      if (frameTick) begin
        statusBitA <= outA;
        statusBitB <= outB;
        userBitA <= usrA;
        userBitB <= usrB;
      end
    end
  end

endmodule

`default_nettype wire

/* File: verif/cu_buffer_manager_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module cu_buffer_manager_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frameTick,
  input wire logic statusBitA,
  input wire logic statusBitB,
  input wire logic userBitA,
  input wire logic userBitB,
  input wire logic bitStrobe,
  input wire logic blockStart,
  input wire logic xferIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // frame count; 191 at reset so the first tick opens a block
  logic [7:0] frameCnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frameCnt <= 8'hBF;
    end else if (bitStrobe) begin
      frameCnt <= blockStart ? 8'h00 : frameCnt + 8'h01;
    end
  end
  property p_tick_strobe;
    frameTick |=> bitStrobe;
  endproperty
  a_tick_strobe: assert property (p_tick_strobe) else $error("no strobe");
  property p_strobe_cause;
    bitStrobe |-> $past(frameTick);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe");
  property p_block_count;
    bitStrobe && blockStart |-> frameCnt == 8'hBF;
  endproperty
  a_block_count: assert property (p_block_count) else $error("early");
  property p_count_block;
    bitStrobe && frameCnt == 8'hBF |-> blockStart;
  endproperty
  a_count_block: assert property (p_count_block) else $error("late");
  property p_irq_frame;
    xferIrq |-> bitStrobe && frameCnt == 8'hBE;
  endproperty
  a_irq_frame: assert property (p_irq_frame) else $error("irq frame");
  property p_bits_hold;
    !bitStrobe |-> $stable({statusBitA, statusBitB, userBitA, userBitB});
  endproperty
  a_bits_hold: assert property (p_bits_hold) else $error("bits moved");
  property p_write_answer;
    s_axi_awready |-> s_axi_wready && s_axi_awvalid ##1 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("wr");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("bresp");
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("rdata");
endmodule
bind cu_buffer_manager cu_buffer_manager_sva #(.ADDR_W(ADDR_W))
  cu_buffer_manager_sva_inst (.core_clk, .arst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .frameTick, .statusBitA, .statusBitB, .userBitA, .userBitB, .bitStrobe,
  .blockStart, .xferIrq);
`default_nettype wire

/* File: verif/frame_tick_source.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// output timebase: a tick every four clocks
// ----------------------------------------
module frame_tick_source (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic run,
  output logic frameTick,
  output logic serialStatusIn
);
  logic [1:0] div;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div <= 2'h0;
      frameTick <= 1'b0;
      serialStatusIn <= 1'b0;
    end else begin
      div <= run ? div + 2'h1 : 2'h0;
      frameTick <= run && (div == 2'h3);
      // toggles so a stale serial level never looks valid
      serialStatusIn <= serialStatusIn ^ frameTick;
    end
  end
endmodule
`default_nettype wire

/* File: verif/channel_status_user_buffer_manager_bench.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module channel_status_user_buffer_manager_bench;
  logic core_clk, arst_n, run, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, sa, sb, ua, ub, ca, cb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic frameTick, serialStatusIn, statusBitA, statusBitB, userBitA;
  logic userBitB, bitStrobe, blockStart, xferIrq, pinMode;
  int fail_count, compares, blkCount, irqSeen;
  int idx = 200;
  cu_buffer_manager #(.ADDR_W(8)) cu_buffer_manager_inst (.core_clk,
    .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frameTick,
    .pinMode, .serialStatusIn, .statusBitA, .statusBitB, .userBitA,
    .userBitB, .bitStrobe, .blockStart, .xferIrq);
  frame_tick_source frame_tick_source_inst (.core_clk, .arst_n, .run,
    .frameTick, .serialStatusIn);
  // first eight frames of each block, frame 0 lands in the msb
  always @(posedge core_clk) begin
    if (bitStrobe === 1'b1) begin
      idx = (blockStart === 1'b1) ? 0 : idx + 1;
      if (blockStart === 1'b1) blkCount++;
      if (idx < 8) begin
        sa[7 - idx] = statusBitA;
        sb[7 - idx] = statusBitB;
        ua[7 - idx] = userBitA;
        ub[7 - idx] = userBitB;
      end
      // last byte of the block, where a check byte may stand
      if (idx >= 184 && idx < 192) begin
        ca[191 - idx] = statusBitA;
        cb[191 - idx] = statusBitB;
      end
    end
    if (xferIrq === 1'b1) irqSeen++;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    s_axi_bready <= 1'b0;
    chk({32'h00000000, s_axi_bresp}, {32'h00000000, 2'h0});
  endtask
  task automatic axiRead(input logic [7:0] a, input logic [7:0] e,
                         input logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, {r, 24'h000000, e});
  endtask
  // waits for k block starts plus the eight captured frames
  task automatic waitBlocks(input int k);
    int target;
    target = blkCount + k;
    for (int n = 0; n < 4000 && !(blkCount >= target && idx >= 8); n++)
      @(posedge core_clk);
    if (!(blkCount >= target && idx >= 8)) begin
      fail_count++;
      $display("Error at %0t: block wait timed out", $time);
    end
  endtask
  // check byte over frames 0..183; only bytes 0 and 1 are nonzero here
  function automatic logic [7:0] crcOf(input logic [7:0] b0,
                                       input logic [7:0] b1);
    logic [7:0] c;
    logic bitIn;
    c = cu_buffer_pkg::CRC_INIT;
    for (int f = 0; f < cu_buffer_pkg::CRC_FIRST_FRAME; f++) begin
      bitIn = (f < 8) ? b0[7 - f] : (f < 16) ? b1[15 - f] : 1'b0;
      c = {c[6:0], 1'b0}
          ^ ((c[7] ^ bitIn) ? cu_buffer_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  task automatic checkBlock(input logic [7:0] a, input logic [7:0] b,
                            input logic [15:0] u);
    logic [7:0] eua, eub;
    for (int f = 0; f < 8; f++) begin
      eua[7 - f] = u[15 - 2 * f];
      eub[7 - f] = u[14 - 2 * f];
    end
    chk({2'h0, sa, sb, ua, ub}, {2'h0, a, b, eua, eub});
  endtask
  task automatic resetScenario();
    axiRead(cu_buffer_pkg::CTRL_OFFSET, 8'h00, 2'h0);
    axiRead(cu_buffer_pkg::STATUS_OFFSET, 8'h00, 2'h0);
    axiRead(cu_buffer_pkg::CS_PTR_OFFSET, 8'h00, 2'h0);
    axiRead(8'h18, 8'h00, 2'h2);
  endtask
  task automatic twoByteScenario();
    axiWrite(cu_buffer_pkg::CTRL_OFFSET, 8'h01);
    axiWrite(cu_buffer_pkg::CS_PTR_OFFSET, 8'h00);
    axiWrite(cu_buffer_pkg::CS_DATA_OFFSET, 8'h5A);
    axiWrite(cu_buffer_pkg::CS_DATA_OFFSET, 8'h3C);
    axiWrite(cu_buffer_pkg::CS_DATA_OFFSET, 8'h77);
    axiWrite(cu_buffer_pkg::USR_PTR_OFFSET, 8'h00);
    axiWrite(cu_buffer_pkg::USR_DATA_OFFSET, 8'hA5);
    axiWrite(cu_buffer_pkg::USR_DATA_OFFSET, 8'h0F);
    axiWrite(cu_buffer_pkg::CS_PTR_OFFSET, 8'h00);
    axiRead(cu_buffer_pkg::CS_DATA_OFFSET, 8'h5A, 2'h0);
    axiRead(cu_buffer_pkg::CS_DATA_OFFSET, 8'h3C, 2'h0);
    axiRead(cu_buffer_pkg::CS_DATA_OFFSET, 8'h77, 2'h0);
  endtask
  task automatic streamScenario();
    run <= 1'b1;
    waitBlocks(2);
    checkBlock(8'h5A, 8'h3C, 16'h0000);
    chk({2'h0, irqSeen}, 34'h0);
  endtask
  task automatic userIrqScenario();
    axiWrite(cu_buffer_pkg::CTRL_OFFSET, 8'h19);
    waitBlocks(2);
    checkBlock(8'h5A, 8'h3C, 16'hA50F);
    chk({33'h0, irqSeen != 0}, 34'h1);
  endtask
  // inhibit first, so no copy can slip in while staging changes
  task automatic inhibitScenario();
    axiWrite(cu_buffer_pkg::CTRL_OFFSET, 8'h04);
    axiWrite(cu_buffer_pkg::CS_PTR_OFFSET, 8'h00);
    axiWrite(cu_buffer_pkg::CS_DATA_OFFSET, 8'h11);
    axiWrite(cu_buffer_pkg::CS_PTR_OFFSET, 8'h00);
    axiRead(cu_buffer_pkg::CS_DATA_OFFSET, 8'h11, 2'h0);
    axiWrite(cu_buffer_pkg::CTRL_OFFSET, 8'h06);
    axiWrite(cu_buffer_pkg::CS_PTR_OFFSET, 8'h00);
    axiRead(cu_buffer_pkg::CS_DATA_OFFSET, 8'h11, 2'h0);
    waitBlocks(2);
    checkBlock(8'h5A, 8'h3C, 16'h0000);
    axiWrite(cu_buffer_pkg::CTRL_OFFSET, 8'h00);
    waitBlocks(2);
    checkBlock(8'h11, 8'h11, 16'h0000);
  endtask
  // pro flag set in both channels; word 1 still holds 77h in A only
  task automatic crcScenario();
    axiWrite(cu_buffer_pkg::CS_PTR_OFFSET, 8'h00);
    axiWrite(cu_buffer_pkg::CS_DATA_OFFSET, 8'h80);
    waitBlocks(2);
    checkBlock(8'h80, 8'h80, 16'h0000);
    chk({18'h00000, ca, cb},
        {18'h00000, crcOf(8'h80, 8'h77), crcOf(8'h80, 8'h00)});
  endtask
  // pin toggles per frame, so frame 0 is zero: not pro, bits pass raw
  task automatic pinScenario();
    pinMode <= 1'b1;
    waitBlocks(2);
    checkBlock(8'h55, 8'h55, 16'h0000);
    chk({18'h00000, ca, cb}, {18'h00000, 8'h55, 8'h55});
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {arst_n, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready, pinMode} = 6'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    resetScenario();
    twoByteScenario();
    streamScenario();
    userIrqScenario();
    inhibitScenario();
    crcScenario();
    pinScenario();
    tally_and_finish();
  end
  // about three times the expected run
  initial begin
    #1500000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
